// ---- hw/serial_port_pkg.sv ----
// constants and types shared by the serial control port design
package serial_port_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h70;
  localparam logic [7:0] WR_IDX_MAX = 8'h0f;
  localparam logic [7:0] RD_IDX_STATUS = 8'h80;
  localparam logic [7:0] RD_IDX_MEASURE = 8'h81;
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_FILTER = 4'h3;
  localparam logic [3:0] REG_TH_LOW = 4'h6;
  localparam logic [3:0] REG_TH_HIGH = 4'h7;
  localparam int CFG_SLICER_BIT = 15;
  localparam int CFG_PWRDN_BIT = 14;
  localparam int CFG_MODE_LSB = 12;
  localparam int FLT_BW_LSB = 4;
  localparam logic [15:0] CONFIG_RST = 16'h0011;
  localparam logic [15:0] FILTER_RST = 16'h0000;
  localparam logic [15:0] OTHER_RST = 16'h0000;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int SYNC_W = 7;
  localparam int REG_COUNT = 16;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'h0,
    BUS_ADDR = 4'h1,
    BUS_ACK = 4'h3,
    BUS_INDEX = 4'h2,
    BUS_DATA = 4'h6,
    BUS_READ = 4'h7,
    BUS_RD_ACK = 4'h5,
    BUS_IGNORE = 4'h4
  } bus_state_t;

  typedef enum logic [1:0] {
    MODE_SLAVE = 2'h0,
    MODE_SELF_POLL = 2'h1,
    MODE_TIMER = 2'h3
  } wake_mode_t;
endpackage : serial_port_pkg

// ---- hw/pin_sync.sv ----
// two-flop synchroniser for the asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync
  import serial_port_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // pins in and synchronised copies out
  input wire logic [SYNC_W-1:0] async_i,
  output logic [SYNC_W-1:0] sync_o
);
  logic [SYNC_W-1:0] meta_q;

  // first stage feeds the second stage only
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : pin_sync

// ---- hw/rate_detector.sv ----
// data-rate window counter of the data-valid detector
`timescale 1ns/1ps
module rate_detector
  import serial_port_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // sliced data and window limits
  input wire logic sliced_i,
  input wire logic [15:0] th_low_i,
  input wire logic [15:0] th_high_i,
  // measurement results
  output logic [15:0] measure_o,
  output logic rate_ok_o
);
  logic [15:0] count_q;
  logic sliced_d_q;
  logic sliced_rise;

  assign sliced_rise = sliced_i & ~sliced_d_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
      sliced_d_q <= 1'b0;
    else
      sliced_d_q <= sliced_i;
  end

  // count timebase cycles between rising edges of the sliced data
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      count_q <= 16'h0000;
      measure_o <= 16'h0000;
      rate_ok_o <= 1'b0;
    end
    else if (sliced_rise)
    begin
      measure_o <= count_q;
      rate_ok_o <= (count_q >= th_low_i) && (count_q <= th_high_i);
      count_q <= 16'h0001;
    end
    else if (count_q != 16'hffff)
      count_q <= count_q + 16'h0001;
    else
      rate_ok_o <= 1'b0;
  end
endmodule : rate_detector

// ---- hw/serial_control_port.sv ----
// serial control port with configuration registers and power-down control
// Summary of operation
// - mode pin low selects two-wire protocol, high selects three-wire protocol
// - port works in power-down; host serial clock edges are sampled on sys_clk_i
// - data changes while clock high are start or stop events only
// - falling data while clock high starts a new command
// - rising data while clock high ends exchange, bus logic goes idle
// - receiver pulls data low on ninth clock after each byte in two-wire mode, except after an unmatched address or unknown index
// - address byte sent msb first; upper seven bits must match device
// - address lsb zero means write, one means read
// - write carries index 00h to 0fh then data bytes, ended by stop
// - read: address write, index 80h or 81h, address read, data out
// - data line driven only low, open drain, pulled up internally
// - power-down when pin high or config bit 14 set
// - config bit 15 picks slicer threshold source, resets to zero
// - filter register bits 4 to 7 set data filter bandwidth
// - rate detector counts timebase cycles gated by sliced data, compares
// - self-polling: rate and strength both pass, power-down pin pulled low
// - power-down pin open drain; outside may pull it low to wake
// - wake-up logic selects slave, self-polling or timer mode
// - three-wire mode ignores traffic while select line is high
`timescale 1ns/1ps
module serial_control_port
  import serial_port_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // bus pins
  input wire logic port_protocol_select_pin_i,
  input wire logic iface_select_b_pin_i,
  input wire logic serial_clock_pin_i,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_o,
  // power-down and data-detect pin
  input wire logic powerdown_detect_pin_i,
  output logic powerdown_detect_pin_o,
  output logic powerdown_detect_pin_oe_o,
  // receiver status inputs
  input wire logic sliced_data_i,
  input wire logic rssi_ok_i,
  // configuration outputs
  output logic [15:0] config_o,
  output logic [7:0] filter_cutoff_register_o,
  output logic slicer_peak_o,
  output logic [3:0] data_filter_bw_o,
  output logic powerdown_o,
  output serial_port_pkg::wake_mode_t wake_mode_o,
  output logic data_valid_o
);
  import serial_port_pkg::*;

  logic [SYNC_W-1:0] sync_s;
  logic scl_s;
  logic sda_s;
  logic three_wire_s;
  logic sel_b_s;
  logic pwdd_s;
  logic rssi_s;
  logic sliced_s;
  logic scl_d_q;
  logic sda_d_q;
  logic sel_b_d_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic sel_fall;
  bus_state_t state_q;
  bus_state_t nxt_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shreg_q;
  logic [7:0] tx_q;
  logic [7:0] hi_byte_q;
  logic hi_sel_q;
  logic [3:0] idx_q;
  logic rd_sel_q;
  logic [15:0] regs_q [REG_COUNT];
  logic byte_done;
  logic wr_en;
  logic [15:0] wr_data;
  logic [15:0] measure;
  logic rate_ok;
  logic pwdd_low_q;

  function automatic logic is_wide(input logic [3:0] idx);
    is_wide = (idx != REG_FILTER);
  endfunction : is_wide

  function automatic logic [15:0] reg_reset(input int idx);
    if (idx == int'(REG_CONFIG))
      reg_reset = CONFIG_RST;
    else if (idx == int'(REG_FILTER))
      reg_reset = FILTER_RST;
    else
      reg_reset = OTHER_RST;
  endfunction : reg_reset

  function automatic logic [7:0] rd_value(input logic sel);
    if (sel)
      rd_value = measure[7:0];
    else
      rd_value = {wake_mode_o, rssi_s, rate_ok, powerdown_o, 3'h0};
  endfunction : rd_value

  pin_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({sliced_data_i, rssi_ok_i, powerdown_detect_pin_i, iface_select_b_pin_i,
              port_protocol_select_pin_i, serial_data_pin_i, serial_clock_pin_i}),
    .sync_o(sync_s)
  );

  assign scl_s = sync_s[0];
  assign sda_s = sync_s[1];
  assign three_wire_s = sync_s[2];
  assign sel_b_s = sync_s[3];
  assign pwdd_s = sync_s[4];
  assign rssi_s = sync_s[5];
  assign sliced_s = sync_s[6];

  // edge detection on the synchronised host clock and data
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      scl_d_q <= 1'b0;
      sda_d_q <= 1'b1;
      sel_b_d_q <= 1'b1;
    end
    else
    begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
      sel_b_d_q <= sel_b_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_q;
  assign scl_fall = ~scl_s & scl_d_q;
  assign start_ev = ~three_wire_s & scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_ev = ~three_wire_s & scl_s & scl_d_q & ~sda_d_q & sda_s;
  assign sel_fall = three_wire_s & sel_b_d_q & ~sel_b_s;
  assign byte_done = scl_fall & (bit_cnt_q == BITS_PER_BYTE);

  // bus protocol state machine
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= BUS_IDLE;
      nxt_q <= BUS_IDLE;
      bit_cnt_q <= 4'h0;
      shreg_q <= 8'h00;
      tx_q <= 8'hff;
      hi_byte_q <= 8'h00;
      hi_sel_q <= 1'b0;
      idx_q <= 4'h0;
      rd_sel_q <= 1'b0;
    end
    else if (three_wire_s && sel_b_s)
    begin
      state_q <= BUS_IDLE;
      bit_cnt_q <= 4'h0;
    end
    else if (sel_fall)
    begin
      state_q <= BUS_INDEX;
      bit_cnt_q <= 4'h0;
      hi_sel_q <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_q <= BUS_IDLE;
      bit_cnt_q <= 4'h0;
    end
    else if (start_ev)
    begin
      state_q <= BUS_ADDR;
      bit_cnt_q <= 4'h0;
      hi_sel_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        BUS_IDLE, BUS_IGNORE:
        begin
          bit_cnt_q <= 4'h0;
        end
        BUS_ADDR, BUS_INDEX, BUS_DATA:
        begin
          if (scl_rise)
          begin
            shreg_q <= {shreg_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (byte_done)
          begin
            bit_cnt_q <= 4'h0;
            state_q <= three_wire_s ? BUS_DATA : BUS_ACK;
            if (state_q == BUS_ADDR)
            begin
              if (shreg_q[7:1] != DEV_ADDR)
                state_q <= BUS_IGNORE;
              else if (shreg_q[0])
                nxt_q <= BUS_READ;
              else
                nxt_q <= BUS_INDEX;
            end
            else if (state_q == BUS_INDEX)
            begin
              if (shreg_q <= WR_IDX_MAX)
              begin
                idx_q <= shreg_q[3:0];
                hi_sel_q <= 1'b0;
                nxt_q <= BUS_DATA;
              end
              else if (shreg_q == RD_IDX_STATUS || shreg_q == RD_IDX_MEASURE)
              begin
                rd_sel_q <= shreg_q[0];
                nxt_q <= BUS_IDLE;
                if (three_wire_s)
                begin
                  state_q <= BUS_READ;
                  tx_q <= rd_value(shreg_q[0]);
                end
              end
              else
                state_q <= BUS_IGNORE;
            end
            else
            begin
              nxt_q <= BUS_DATA;
              if (is_wide(idx_q) && !hi_sel_q)
              begin
                hi_byte_q <= shreg_q;
                hi_sel_q <= 1'b1;
              end
              else
              begin
                hi_sel_q <= 1'b0;
                idx_q <= idx_q + 4'h1;
              end
            end
          end
        end
        BUS_ACK:
        begin
          if (scl_fall)
          begin
            state_q <= nxt_q;
            if (nxt_q == BUS_READ)
              tx_q <= rd_value(rd_sel_q);
          end
        end
        BUS_READ:
        begin
          if (scl_rise)
            bit_cnt_q <= bit_cnt_q + 4'h1;
          else if (byte_done)
          begin
            bit_cnt_q <= 4'h0;
            state_q <= three_wire_s ? BUS_IGNORE : BUS_RD_ACK;
          end
          else if (scl_fall)
            tx_q <= {tx_q[6:0], 1'b1};
        end
        BUS_RD_ACK:
        begin
          if (scl_rise)
            shreg_q <= {7'h00, sda_s};
          else if (scl_fall)
          begin
            if (!shreg_q[0])
            begin
              state_q <= BUS_READ;
              tx_q <= rd_value(rd_sel_q);
            end
            else
              state_q <= BUS_IGNORE;
          end
        end
        default:
        begin
          state_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // open-drain data line, low only during acknowledge or a zero read bit
  assign serial_data_pin_o = 1'b0;
  assign serial_data_pin_oe_o = (state_q == BUS_ACK) | ((state_q == BUS_READ) & ~tx_q[7]);

  assign wr_en = byte_done & (state_q == BUS_DATA) & ~(is_wide(idx_q) & ~hi_sel_q);
  assign wr_data = is_wide(idx_q) ? {hi_byte_q, shreg_q} : {8'h00, shreg_q};

  // configuration register file
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        regs_q[i] <= reg_reset(i);
    end
    else if (wr_en && !(three_wire_s && sel_b_s) && !stop_ev && !start_ev)
      regs_q[idx_q] <= wr_data;
  end

  rate_detector u_rate (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .sliced_i(sliced_s),
    .th_low_i(regs_q[REG_TH_LOW]),
    .th_high_i(regs_q[REG_TH_HIGH]),
    .measure_o(measure),
    .rate_ok_o(rate_ok)
  );

  // wake-up mode selection and data-valid indication
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      wake_mode_o <= MODE_SLAVE;
      pwdd_low_q <= 1'b0;
    end
    else
    begin
      unique case (regs_q[REG_CONFIG][CFG_MODE_LSB +: 2])
        2'h1: wake_mode_o <= MODE_SELF_POLL;
        2'h2, 2'h3: wake_mode_o <= MODE_TIMER;
        default: wake_mode_o <= MODE_SLAVE;
      endcase
      pwdd_low_q <= (wake_mode_o == MODE_SELF_POLL) & rate_ok & rssi_s;
    end
  end

  assign powerdown_detect_pin_o = 1'b0;
  assign powerdown_detect_pin_oe_o = pwdd_low_q;
  assign powerdown_o = pwdd_s | regs_q[REG_CONFIG][CFG_PWRDN_BIT];
  assign data_valid_o = pwdd_low_q;
  assign config_o = regs_q[REG_CONFIG];
  assign filter_cutoff_register_o = regs_q[REG_FILTER][7:0];
  assign slicer_peak_o = regs_q[REG_CONFIG][CFG_SLICER_BIT];
  assign data_filter_bw_o = regs_q[REG_FILTER][FLT_BW_LSB +: 4];
endmodule : serial_control_port

// ---- bench/scp_assertions.sv ----
// concurrent checks on the serial control port pins and outputs
`timescale 1ns/1ps
module scp_assertions
  import serial_port_pkg::*;
(
  // clock, reset and pins
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic port_protocol_select_pin_i,
  input wire logic iface_select_b_pin_i,
  input wire logic serial_clock_pin_i,
  input wire logic powerdown_detect_pin_i,
  input wire logic serial_data_pin_o,
  input wire logic serial_data_pin_oe_o,
  input wire logic powerdown_detect_pin_o,
  input wire logic powerdown_detect_pin_oe_o,
  // configuration outputs
  input wire logic [15:0] config_o,
  input wire logic [7:0] filter_cutoff_register_o,
  input wire logic slicer_peak_o,
  input wire logic [3:0] data_filter_bw_o,
  input wire logic powerdown_o,
  input wire serial_port_pkg::wake_mode_t wake_mode_o,
  input wire logic data_valid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_pin_high;
    powerdown_detect_pin_i [*5];
  endsequence
  sequence s_pin_low;
    !powerdown_detect_pin_i [*5];
  endsequence
  sequence s_deselected;
    (port_protocol_select_pin_i && iface_select_b_pin_i) [*5];
  endsequence
  sequence s_cfg_steady;
    ($stable(config_o) && $stable(filter_cutoff_register_o)) [*2];
  endsequence
  a_slicer_source: assert property (s_cfg_steady |-> slicer_peak_o == config_o[15])
    else $error("slicer source differs from config bit");
  a_bw_field: assert property (s_cfg_steady |->
    data_filter_bw_o == filter_cutoff_register_o[7:4])
    else $error("filter bandwidth field differs");
  a_wake_mode: assert property (s_cfg_steady |->
    wake_mode_o == (config_o[13] ? MODE_TIMER : config_o[12] ? MODE_SELF_POLL : MODE_SLAVE))
    else $error("wake mode differs from config");
  a_pd_bit: assert property (config_o[CFG_PWRDN_BIT] |-> powerdown_o)
    else $error("config power-down bit ignored");
  a_pd_pin_high: assert property (s_pin_high |-> powerdown_o)
    else $error("power-down pin high ignored");
  a_pd_pin_low: assert property (
    s_pin_low ##0 !config_o[CFG_PWRDN_BIT] |-> !powerdown_o)
    else $error("device not on with pin low");
  a_drive_low_only: assert property (!serial_data_pin_o && !powerdown_detect_pin_o)
    else $error("open-drain pin driven high");
  a_valid_needs_mode: assert property (powerdown_detect_pin_oe_o |->
    $past(wake_mode_o) == MODE_SELF_POLL && data_valid_o) else $error("data valid outside self poll");
  a_data_clock_low: assert property (
    !$stable(serial_data_pin_oe_o) |-> !serial_clock_pin_i)
    else $error("data changed while clock high");
  a_deselect_quiet: assert property (s_deselected |-> !serial_data_pin_oe_o)
    else $error("data driven while deselected");
endmodule : scp_assertions
bind serial_control_port scp_assertions scp_assertions_i (.sys_clk_i, .rst_b_i,
  .port_protocol_select_pin_i, .iface_select_b_pin_i, .serial_clock_pin_i,
  .powerdown_detect_pin_i, .serial_data_pin_o, .serial_data_pin_oe_o, .powerdown_detect_pin_o,
  .powerdown_detect_pin_oe_o, .config_o, .filter_cutoff_register_o, .slicer_peak_o,
  .data_filter_bw_o, .powerdown_o, .wake_mode_o, .data_valid_o);

// ---- bench/host_master.sv ----
// serial bus master model, open-drain data, clock still between frames
`timescale 1ns/1ps
module host_master (
  // pins
  output logic scl_o,
  output logic sda_oe_o,
  input wire logic sda_i
);
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    scl_o = 1'b0;
    #100 sda_oe_o = ~b;
    #100 scl_o = 1'b1;
    #100 r = sda_i;
    #100;
  endtask : bit_io
  task automatic start;
    scl_o = 1'b0;
    #100 sda_oe_o = 1'b0;
    #100 scl_o = 1'b1;
    #100 sda_oe_o = 1'b1;
    #100;
  endtask : start
  task automatic stop;
    scl_o = 1'b0;
    #100 sda_oe_o = 1'b1;
    #100 scl_o = 1'b1;
    #100 sda_oe_o = 1'b0;
    #100;
  endtask : stop
  // trailing falling edge closes the last three-wire byte
  task automatic clk_low;
    scl_o = 1'b0;
    #200;
  endtask : clk_low
  task automatic send(input logic [7:0] d, input logic acked, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    if (acked) bit_io(1'b1, r);
    ack = ~r;
  endtask : send
  task automatic recv(input logic acked, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    if (acked) bit_io(1'b1, r);
  endtask : recv
endmodule : host_master

// ---- bench/test_serial_control_port.sv ----
// self-checking testbench for the serial control port
`timescale 1ns/1ps
module test_serial_control_port;
  import serial_port_pkg::*;
  logic clk = 1'b0;
  logic rst_b, proto, sel_b, scl, m_oe, sda, d_oe, pd_low, pd_pin, pd_oe, sl_en, rssi;
  logic slicer, pdn, valid;
  logic [4:0] sl_cnt = 5'h00;
  logic [15:0] cfg;
  logic [7:0] flt, rd_d;
  logic [3:0] bw;
  wake_mode_t mode;
  int errors = 0, compares = 0, cycles = 0;
  always #25 clk = ~clk;
  assign sda = ~(d_oe | m_oe);
  assign pd_pin = ~(pd_oe | pd_low);
  always @(posedge clk) sl_cnt <= sl_en ? sl_cnt + 5'h01 : 5'h00;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      end_sim();
    end
  end
  serial_control_port serial_control_port_i (.sys_clk_i(clk), .rst_b_i(rst_b),
    .port_protocol_select_pin_i(proto), .iface_select_b_pin_i(sel_b), .serial_clock_pin_i(scl),
    .serial_data_pin_i(sda), .serial_data_pin_o(), .serial_data_pin_oe_o(d_oe),
    .powerdown_detect_pin_i(pd_pin), .powerdown_detect_pin_o(), .powerdown_detect_pin_oe_o(pd_oe),
    .sliced_data_i(sl_cnt[4]), .rssi_ok_i(rssi), .config_o(cfg), .filter_cutoff_register_o(flt),
    .slicer_peak_o(slicer), .data_filter_bw_o(bw), .powerdown_o(pdn), .wake_mode_o(mode),
    .data_valid_o(valid));
  host_master host_master_i (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic check_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : check_flag
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk
  task automatic head(input logic [7:0] idx);
    logic a;
    host_master_i.start();
    host_master_i.send({DEV_ADDR, 1'b0}, 1'b1, a);
    check_flag(a, 1'b1);
    host_master_i.send(idx, 1'b1, a);
    check_flag(a, 1'b1);
  endtask : head
  task automatic reg_wr(input logic [7:0] idx, input logic [15:0] d, input int n);
    logic a;
    head(idx);
    if (n == 2) host_master_i.send(d[15:8], 1'b1, a);
    if (n == 2) check_flag(a, 1'b1);
    host_master_i.send(d[7:0], 1'b1, a);
    check_flag(a, 1'b1);
    host_master_i.stop();
    wait_clk(8);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] idx);
    logic a;
    head(idx);
    host_master_i.start();
    host_master_i.send({DEV_ADDR, 1'b1}, 1'b1, a);
    check_flag(a, 1'b1);
    host_master_i.recv(1'b1, rd_d);
    host_master_i.stop();
  endtask : reg_rd
  task automatic t_reset;
    check_val(cfg, CONFIG_RST);
    check_val({8'h00, flt}, FILTER_RST);
    check_flag(slicer, 1'b0);
    check_val({14'h0000, mode}, {14'h0000, MODE_SLAVE});
    check_flag(pdn, 1'b0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_config;
    reg_wr(8'h00, 16'hc000, 2);
    check_val(cfg, 16'hc000);
    check_flag(slicer, 1'b1);
    check_flag(pdn, 1'b1);
    reg_wr(8'h00, 16'h3011, 2);
    check_val(cfg, 16'h3011);
    check_val({14'h0000, mode}, {14'h0000, MODE_TIMER});
    check_flag(pdn, 1'b0);
    reg_wr(8'h03, 16'h00a5, 1);
    check_val({8'h00, flt}, 16'h00a5);
    check_val({12'h000, bw}, 16'h000a);
    $display("t_config done");
  endtask : t_config
  task automatic t_bad_addr;
    logic a;
    host_master_i.start();
    host_master_i.send(8'he2, 1'b1, a);
    check_flag(a, 1'b0);
    host_master_i.send(8'h00, 1'b1, a);
    host_master_i.send(8'h55, 1'b1, a);
    host_master_i.send(8'h55, 1'b1, a);
    host_master_i.stop();
    wait_clk(8);
    check_val(cfg, 16'h3011);
    $display("t_bad_addr done");
  endtask : t_bad_addr
  task automatic t_valid;
    reg_wr(8'h06, 16'h0010, 2);
    reg_wr(8'h07, 16'h0030, 2);
    reg_wr(8'h00, 16'h1011, 2);
    rssi = 1'b1;
    sl_en = 1'b1;
    pd_low = 1'b0;
    wait_clk(200);
    check_flag(valid, 1'b1);
    check_flag(pd_pin, 1'b0);
    check_flag(pdn, 1'b0);
    reg_rd(RD_IDX_STATUS);
    check_val({8'h00, rd_d & 8'hef}, 16'h0060);
    reg_rd(RD_IDX_MEASURE);
    check_val({8'h00, rd_d}, 16'h0020);
    rssi = 1'b0;
    wait_clk(10);
    check_flag(valid, 1'b0);
    check_flag(pdn, 1'b1);
    pd_low = 1'b1;
    wait_clk(6);
    check_flag(pdn, 1'b0);
    $display("t_valid done");
  endtask : t_valid
  task automatic t_three_wire;
    logic a;
    proto = 1'b1;
    sel_b = 1'b1;
    wait_clk(4);
    host_master_i.send(8'h03, 1'b0, a);
    host_master_i.send(8'hff, 1'b0, a);
    wait_clk(8);
    check_val({8'h00, flt}, 16'h00a5);
    sel_b = 1'b0;
    wait_clk(4);
    host_master_i.send(8'h03, 1'b0, a);
    host_master_i.send(8'h3c, 1'b0, a);
    host_master_i.clk_low();
    wait_clk(8);
    sel_b = 1'b1;
    wait_clk(4);
    check_val({8'h00, flt}, 16'h003c);
    sel_b = 1'b0;
    wait_clk(4);
    host_master_i.send(RD_IDX_MEASURE, 1'b0, a);
    host_master_i.recv(1'b0, rd_d);
    host_master_i.clk_low();
    wait_clk(4);
    sel_b = 1'b1;
    check_val({8'h00, rd_d}, 16'h0020);
    $display("t_three_wire done");
  endtask : t_three_wire
  task automatic end_sim;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial
  begin
    {rst_b, proto, sel_b, sl_en, rssi} = 5'h00;
    pd_low = 1'b1;
    wait_clk(16);
    rst_b = 1'b1;
    wait_clk(4);
    t_reset();
    t_config();
    t_bad_addr();
    t_valid();
    t_three_wire();
    end_sim();
  end
endmodule : test_serial_control_port
